/* design/lss_pkg.sv */
package lss_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MASK   = 8'h04;
   localparam logic [7:0] REG_CONFIG = 8'h08;
   localparam logic [7:0] REG_LATCH  = 8'h0C;
   localparam logic [7:0] REG_FAULT  = 8'h10;
   localparam logic [7:0] REG_CTRL   = 8'h14;
   // Status and mask bit positions
   localparam int ST_LATCHED = 0;
   localparam int ST_CFG     = 1;
   localparam int ST_DET     = 2;
   localparam int ST_OPEN    = 3;
   localparam int ST_W       = 4;
   // Control bit: software forced blanking
   localparam int CTRL_FORCE_OFF = 0;
   // Configuration field layout: six bit gain code
   localparam int GAIN_LSB = 0;
   localparam int GAIN_W   = 6;
   // Reset values
   localparam logic [15:0]   CFG_RST  = 16'h0000;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;
   // Command selectors: rising serial clock edges seen with the strobe high
   localparam logic [4:0] CMD_CFG_CNT = 5'h0B;
   localparam logic [4:0] CMD_DET_CNT = 5'h07;
   // Open detection test window
   localparam int CLK_MHZ     = 25;
   localparam int DET_TIME_NS = 1000;
   localparam logic [7:0] DET_CYC = 8'((DET_TIME_NS * CLK_MHZ + 999) / 1000);
   // Stagger: last channel index
   localparam logic [3:0] STG_LAST = 4'hF;
   // Controller states
   typedef enum logic {LSS_IDLE, LSS_DETECT} lss_state_e;
endpackage : lss_pkg

/* design/lss_top.sv */
`timescale 1ns/1ns
`default_nettype none
module lss_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        serial_clk,
   input  wire logic        serial_in,
   input  wire logic        latch_strobe,
   input  wire logic        blank_b,
   input  wire logic [15:0] open_sense,
   output logic             serial_out,
   output logic [15:0]      sink_channels,
   output logic             test_current,
   output logic [5:0]       gain_code,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq
);

   typedef struct packed {
      logic                    sclk_s1;
      logic                    sclk_s2;
      logic                    sclk_d;
      logic                    sdi_s1;
      logic                    sdi_s2;
      logic                    le_s1;
      logic                    le_s2;
      logic                    le_d;
      logic                    blk_s1;
      logic                    blk_s2;
      logic [15:0]             opn_s1;
      logic [15:0]             opn_s2;
      logic [15:0]             shift;
      logic [15:0]             latch;
      logic [15:0]             cfg;
      logic [15:0]             fault;
      logic [4:0]              cnt;
      lss_pkg::lss_state_e     st;
      logic [7:0]              det_cnt;
      logic [15:0]             tgt;
      logic [3:0]              stg;
      logic [15:0]             sinks;
      logic [lss_pkg::ST_W-1:0] status;
      logic [lss_pkg::ST_W-1:0] mask;
      logic                    force_off;
      logic                    ack;
      logic [31:0]             dat;
   } lss_regs_s;

   lss_regs_s q_r;
   lss_regs_s q_nxt;

   logic        sclk_rise;
   logic        le_fall;
   logic        wr_go;
   logic [15:0] target;
   logic [lss_pkg::ST_W-1:0] ev;

   // Edge detection only on second stage flops
   assign sclk_rise = q_r.sclk_s2 & ~q_r.sclk_d;
   assign le_fall   = q_r.le_d & ~q_r.le_s2;
   // Write commits on the edge the master samples ack
   assign wr_go     = q_r.ack & wb_cyc_i & wb_stb_i & wb_we_i;

   // Sink target before staggering
   always_comb begin
      if (q_r.st == lss_pkg::LSS_DETECT) begin
         target = {16{~q_r.blk_s2}};
      end else if (q_r.blk_s2 | q_r.force_off) begin
         target = 16'h0000;
      end else begin
         target = q_r.latch;
      end
   end

   // Next state of the whole block
   always_comb begin
      q_nxt = q_r;
      ev    = '0;
      // Pin synchronisers
      q_nxt.sclk_s1 = serial_clk;
      q_nxt.sclk_s2 = q_r.sclk_s1;
      q_nxt.sclk_d  = q_r.sclk_s2;
      q_nxt.sdi_s1  = serial_in;
      q_nxt.sdi_s2  = q_r.sdi_s1;
      q_nxt.le_s1   = latch_strobe;
      q_nxt.le_s2   = q_r.le_s1;
      q_nxt.le_d    = q_r.le_s2;
      q_nxt.blk_s1  = blank_b;
      q_nxt.blk_s2  = q_r.blk_s1;
      q_nxt.opn_s1  = open_sense;
      q_nxt.opn_s2  = q_r.opn_s1;

      // Serial path: shift only while the strobe is low
      if (sclk_rise && !q_r.le_s2) begin
         q_nxt.shift = {q_r.shift[14:0], q_r.sdi_s2};
      end
      // Edges under a high strobe count as a command selector
      if (sclk_rise && q_r.le_s2 && q_r.cnt != 5'h1F) begin
         q_nxt.cnt = q_r.cnt + 5'h01;
      end

      // Decode at the strobe falling edge
      if (le_fall) begin
         q_nxt.cnt = 5'h00;
         if (q_r.cnt == lss_pkg::CMD_CFG_CNT) begin
            q_nxt.cfg = q_r.shift;
            ev[lss_pkg::ST_CFG] = 1'b1;
         end else if (q_r.cnt == lss_pkg::CMD_DET_CNT) begin
            q_nxt.st      = lss_pkg::LSS_DETECT;
            q_nxt.det_cnt = lss_pkg::DET_CYC;
         end else begin
            q_nxt.latch = q_r.shift;
            ev[lss_pkg::ST_LATCHED] = 1'b1;
         end
      end

      // Detection window; a new strobe edge cannot restart it
      unique case (q_r.st)
         lss_pkg::LSS_IDLE: begin
         end
         lss_pkg::LSS_DETECT: begin
            if (q_r.det_cnt == 8'h01) begin
               q_nxt.st    = lss_pkg::LSS_IDLE;
               q_nxt.shift = q_r.opn_s2;
               q_nxt.fault = q_r.opn_s2;
               ev[lss_pkg::ST_DET]  = 1'b1;
               ev[lss_pkg::ST_OPEN] = |q_r.opn_s2;
            end else begin
               q_nxt.det_cnt = q_r.det_cnt - 8'h01;
            end
         end
      endcase

      // Stagger: channel i follows the target i+2 cycles after a change
      if (target != q_r.tgt) begin
         q_nxt.tgt = target;
         q_nxt.stg = 4'h0;
      end else if (q_r.stg != lss_pkg::STG_LAST) begin
         q_nxt.stg = q_r.stg + 4'h1;
      end
      for (int i = 0; i < 16; i++) begin
         if (4'(i) <= q_r.stg) begin
            q_nxt.sinks[i] = q_r.tgt[i];
         end
      end

      // Wishbone slave: ack one cycle after the request, one cycle wide
      q_nxt.ack = wb_cyc_i & wb_stb_i & ~q_r.ack;
      if (wb_cyc_i && wb_stb_i && !q_r.ack) begin
         unique case (wb_adr_i)
            lss_pkg::REG_STATUS: q_nxt.dat = {28'h000_0000, q_r.status};
            lss_pkg::REG_MASK:   q_nxt.dat = {28'h000_0000, q_r.mask};
            lss_pkg::REG_CONFIG: q_nxt.dat = {16'h0000, q_r.cfg};
            lss_pkg::REG_LATCH:  q_nxt.dat = {16'h0000, q_r.latch};
            lss_pkg::REG_FAULT:  q_nxt.dat = {16'h0000, q_r.fault};
            lss_pkg::REG_CTRL:   q_nxt.dat = {31'h0000_0000, q_r.force_off};
            default:             q_nxt.dat = 32'h0000_0000;
         endcase
      end

      // Register writes; status is write one to clear
      if (wr_go && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            lss_pkg::REG_STATUS: begin
               q_nxt.status = q_r.status & ~wb_dat_i[lss_pkg::ST_W-1:0];
            end
            lss_pkg::REG_MASK: q_nxt.mask = wb_dat_i[lss_pkg::ST_W-1:0];
            lss_pkg::REG_CONFIG: q_nxt.cfg[7:0] = wb_dat_i[7:0];
            lss_pkg::REG_CTRL: q_nxt.force_off = wb_dat_i[lss_pkg::CTRL_FORCE_OFF];
            default: begin
            end
         endcase
      end
      if (wr_go && wb_sel_i[1] && wb_adr_i == lss_pkg::REG_CONFIG) begin
         q_nxt.cfg[15:8] = wb_dat_i[15:8];
      end
      // A pin command outranks a software config write
      if (ev[lss_pkg::ST_CFG]) begin
         q_nxt.cfg = q_r.shift;
      end
      // Hardware set wins over a clear in the same cycle
      q_nxt.status = q_nxt.status | ev;
   end

   // Single register stage; blanking synchroniser starts high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q_r        <= '0;
         q_r.blk_s1 <= 1'b1;
         q_r.blk_s2 <= 1'b1;
         q_r.cfg    <= lss_pkg::CFG_RST;
         q_r.mask   <= lss_pkg::MASK_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Outputs
   assign serial_out    = q_r.shift[15];
   assign sink_channels = q_r.sinks;
   assign test_current  = (q_r.st == lss_pkg::LSS_DETECT);
   assign gain_code     = q_r.cfg[lss_pkg::GAIN_LSB +: lss_pkg::GAIN_W];
   assign wb_dat_o      = q_r.dat;
   assign wb_ack_o      = q_r.ack;
   assign irq           = |(q_r.status & q_r.mask);

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   shift_advance_a: assert property (sclk_rise && !q_r.le_s2 |=>
      q_r.shift == {$past(q_r.shift[14:0]), $past(q_r.sdi_s2)})
      else $error("shift register did not advance");

   serial_tail_a: assert property (sclk_rise && !q_r.le_s2 && q_r.st == lss_pkg::LSS_IDLE
      |=> serial_out == $past(q_r.shift[14]))
      else $error("serial_out not last stage");

   cmd_no_shift_a: assert property (q_r.le_s2 && q_r.st == lss_pkg::LSS_IDLE
      |=> $stable(q_r.shift))
      else $error("shift moved under high strobe");

   data_latch_a: assert property (le_fall && q_r.cnt != lss_pkg::CMD_CFG_CNT
      && q_r.cnt != lss_pkg::CMD_DET_CNT |=> q_r.latch == $past(q_r.shift))
      else $error("data not latched at strobe fall");

   config_load_a: assert property (le_fall && q_r.cnt == lss_pkg::CMD_CFG_CNT
      |=> q_r.cfg == $past(q_r.shift) && $stable(q_r.latch))
      else $error("config command mishandled");

   detect_start_a: assert property (le_fall && q_r.cnt == lss_pkg::CMD_DET_CNT
      && q_r.st == lss_pkg::LSS_IDLE |=> test_current ##25 $fell(test_current))
      else $error("detection window length wrong");

   detect_result_a: assert property ($fell(test_current) |->
      q_r.shift == $past(q_r.opn_s2) && q_r.fault == q_r.shift)
      else $error("open results not captured");

   blank_off_a: assert property ((q_r.blk_s2 && q_r.st == lss_pkg::LSS_IDLE)[*8]
      ##1 (q_r.blk_s2 && q_r.st == lss_pkg::LSS_IDLE)[*8]
      ##1 (q_r.blk_s2 && q_r.st == lss_pkg::LSS_IDLE)[*3] |-> sink_channels == 16'h0000)
      else $error("sinks on while blanked");

   detect_all_a: assert property ((!q_r.blk_s2 && test_current)[*8]
      ##1 (!q_r.blk_s2 && test_current)[*8] ##1 (!q_r.blk_s2 && test_current)[*3]
      |-> sink_channels == 16'hFFFF)
      else $error("detection missed channels");

   stagger_a: assert property (target != q_r.tgt |=>
      sink_channels[15] == $past(sink_channels[15]) ##1
      sink_channels[15] == $past(sink_channels[15]))
      else $error("last channel switched without delay");

   // Every event must leave its sticky bit set, even against a same cycle clear
   status_set_a: assert property (ev != '0 |=> (q_r.status & $past(ev)) == $past(ev))
      else $error("status event lost");

   cfg_cmd_c:  cover property (le_fall && q_r.cnt == lss_pkg::CMD_CFG_CNT);
   det_cmd_c:  cover property ($fell(test_current) && q_r.fault != 16'h0000);
   latch_on_c: cover property (le_fall ##[1:40] sink_channels != 16'h0000);

endmodule : lss_top
`default_nettype wire

/* dv/lss_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Display controller model on the driver's serial pins
module lss_ctl_model (
   input  wire logic clk,
   output logic      serial_clk,
   output logic      serial_in,
   output logic      latch_strobe,
   output logic      blank_b
);
   // Serial clock rests low outside frames; sinks blanked until told
   initial begin
      serial_clk   = 1'b0;
      serial_in    = 1'b0;
      latch_strobe = 1'b0;
      blank_b      = 1'b1;
   end
   // Four clk per phase, well above the synchroniser minimum
   task automatic tick;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b0;
   endtask : tick
   // Bits go MSB first; stale data line flips so no old value lingers
   task automatic send(input logic [15:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_in <= d[i];
         tick();
      end
      serial_in <= ~serial_in;
      @(posedge clk);
   endtask : send
   // Strobe pulse, clock pulses inside it select a command
   task automatic strobe(input int pulses);
      repeat (4) @(posedge clk);
      latch_strobe <= 1'b1;
      repeat (pulses) tick();
      repeat (4) @(posedge clk);
      latch_strobe <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : strobe
   // Blanking is driven actively for detection to work
   task automatic blank(input logic v);
      @(posedge clk);
      blank_b <= v;
   endtask : blank
endmodule : lss_ctl_model
`default_nettype wire

/* dv/lss_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module lss_top_tb;
   logic        clk, rst_b, serial_clk, serial_in, latch_strobe, blank_b;
   logic        serial_out, test_current, irq, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, rd;
   logic [15:0] open_sense, sinks, ref_shift, word, cfg, exp_cfg;
   logic [3:0]  bsel;
   logic [31:0] rnd;
   logic [5:0]  gain;
   int          fail_count, checked, n;
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   lss_top dut_u (.clk(clk), .rst_b(rst_b), .serial_clk(serial_clk), .serial_in(serial_in),
      .latch_strobe(latch_strobe), .blank_b(blank_b), .open_sense(open_sense),
      .serial_out(serial_out), .sink_channels(sinks), .test_current(test_current),
      .gain_code(gain), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
   lss_ctl_model ctl_u (.clk(clk), .serial_clk(serial_clk), .serial_in(serial_in),
      .latch_strobe(latch_strobe), .blank_b(blank_b));
   // Verdict and exit
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Classic single cycle; held until ack is sampled
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= bsel;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         end_of_test();
      end
   endtask : wb
   // Reference shift register follows every bit sent
   task push(input logic [15:0] d, input int k);
      for (int i = k - 1; i >= 0; i--)
         ref_shift = {ref_shift[14:0], d[i]};
      ctl_u.send(d, k);
      repeat (4) @(posedge clk);
   endtask : push
   // Bounded wait: which 0 test_current, 1 lowest sink
   task wait_on(input int which, input logic v);
      n = 0;
      while (((which == 0) ? test_current : sinks[0]) !== v && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         fail_count++;
         end_of_test();
      end
   endtask : wait_on
   // Main sequence
   initial begin
      rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
      wdat = 32'h0000_0000; open_sense = 16'h0000; ref_shift = 16'h0000;
      bsel = 4'hF;
      fail_count = 0; checked = 0;
      void'($urandom(32'h7a9f_eaeb));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      chk(sinks, 0);
      wb(1'b0, lss_pkg::REG_CONFIG, 0);
      chk(rd, lss_pkg::CFG_RST);
      wb(1'b0, lss_pkg::REG_MASK, 0);
      chk(rd, lss_pkg::MASK_RST);
      $display("test reset done");
      word = 16'($urandom) | 16'h8001;
      ctl_u.blank(1'b0);
      push(word, 16);
      chk(serial_out, ref_shift[15]);
      ctl_u.strobe(0);
      wait_on(1, 1'b1);
      chk(sinks[15], 0);
      repeat (20) @(posedge clk);
      chk(sinks, word);
      wb(1'b0, lss_pkg::REG_LATCH, 0);
      chk(rd, word);
      ctl_u.blank(1'b1);
      repeat (20) @(posedge clk);
      chk(sinks, 0);
      ctl_u.blank(1'b0);
      $display("test latch done");
      cfg = 16'($urandom);
      push(cfg, 16);
      ctl_u.strobe(11);
      chk(gain, cfg[5:0]);
      chk(serial_out, ref_shift[15]);
      chk(sinks, word);
      wb(1'b0, lss_pkg::REG_CONFIG, 0);
      chk(rd, cfg);
      ctl_u.strobe(3);
      repeat (20) @(posedge clk);
      chk(sinks, cfg);
      // Software blanking must override the latched pattern
      wb(1'b1, lss_pkg::REG_CTRL, 32'h0000_0001);
      repeat (20) @(posedge clk);
      chk(sinks, 0);
      wb(1'b0, lss_pkg::REG_CTRL, 0);
      chk(rd, 1);
      wb(1'b1, lss_pkg::REG_CTRL, 0);
      repeat (20) @(posedge clk);
      chk(sinks, cfg);
      push(16'($urandom), 4);
      chk(serial_out, ref_shift[15]);
      // Software config write with random byte enables; only low two lanes count
      rnd = $urandom;
      bsel = 4'($urandom);
      wb(1'b1, lss_pkg::REG_CONFIG, rnd);
      exp_cfg = cfg;
      if (bsel[0]) exp_cfg[7:0] = rnd[7:0];
      if (bsel[1]) exp_cfg[15:8] = rnd[15:8];
      bsel = 4'hF;
      wb(1'b0, lss_pkg::REG_CONFIG, 0);
      chk(rd, exp_cfg);
      chk(gain, exp_cfg[5:0]);
      $display("test config done");
      wb(1'b1, lss_pkg::REG_MASK, 32'h0000_0004);
      wb(1'b1, lss_pkg::REG_STATUS, 32'h0000_000F);
      chk(irq, 0);
      open_sense <= 16'($urandom);
      ctl_u.strobe(7);
      wait_on(0, 1'b1);
      // Window lasts 25 cycles; look after the stagger, well before the end
      repeat (16) @(posedge clk);
      chk(sinks, 16'hFFFF);
      wait_on(0, 1'b0);
      repeat (4) @(posedge clk);
      ref_shift = open_sense;
      chk(serial_out, ref_shift[15]);
      wb(1'b0, lss_pkg::REG_FAULT, 0);
      chk(rd, open_sense);
      chk(irq, 1);
      for (int i = 0; i < 15; i++) begin
         push(16'h0000, 1);
         chk(serial_out, ref_shift[15]);
      end
      wb(1'b1, lss_pkg::REG_STATUS, 32'h0000_0004);
      // Clear lands at the ack edge; irq is combinational and drops with it
      @(posedge clk);
      chk(irq, 0);
      wb(1'b0, 8'hFC, 0);
      chk(rd, 0);
      $display("test detect done");
      end_of_test();
   end
endmodule : lss_top_tb
`default_nettype wire
